// [rtl/fcl_pkg.sv]
// package of register map, reset values and field layout for the fan control limit bank
package fcl_pkg;
	// register indices; the byte address on the bus is index * 4
	localparam logic [7:0] IDX_RAMP_B = 8'h63;
	localparam logic [7:0] IDX_FLOOR1 = 8'h64;
	localparam logic [7:0] IDX_FLOOR2 = 8'h65;
	localparam logic [7:0] IDX_FLOOR3 = 8'h66;
	localparam logic [7:0] IDX_START_R1 = 8'h67;
	localparam logic [7:0] IDX_START_LO = 8'h68;
	localparam logic [7:0] IDX_START_R2 = 8'h69;
	localparam logic [7:0] IDX_CRIT_R1 = 8'h6a;
	localparam logic [7:0] IDX_CRIT_LO = 8'h6b;
	localparam logic [7:0] IDX_CRIT_R2 = 8'h6c;
	localparam logic [7:0] IDX_HYST_A = 8'h6d;
	localparam logic [7:0] IDX_HYST_B = 8'h6e;
	localparam logic [7:0] IDX_TEST = 8'h6f;
	// own registers
	localparam logic [7:0] IDX_CTRL = 8'h80;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h81;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h82;
	localparam logic [7:0] IDX_STATE = 8'h83;
	// reset values
	localparam logic [7:0] RST_RAMP_B = 8'h00;
	localparam logic [7:0] RST_FLOOR = 8'h80;
	localparam logic [7:0] RST_START = 8'h5a;
	localparam logic [7:0] RST_CRIT = 8'h64;
	localparam logic [7:0] RST_HYST_A = 8'h44;
	localparam logic [7:0] RST_HYST_B = 8'h40;
	localparam logic [7:0] RST_TEST = 8'h00;
	localparam logic [7:0] CRIT_OFF_CODE = 8'h80;
	localparam logic [7:0] DUTY_FULL = 8'hff;
	// field positions
	localparam int CTRL_LOCK_BIT = 0;
	localparam int CTRL_AUTO_BIT = 1;
	localparam int CTRL_PIN_OUT_BIT = 2;
	localparam int TEST_ON_BIT = 0;
	localparam int RAMP_ON_BIT = 7;
	localparam int RAMP_STEP_LSB = 4;
	localparam int HYST_LO_LSB = 0;
	localparam int HYST_HI_LSB = 4;
	// interrupt status bits
	localparam int EV_CRIT = 0;
	localparam int EV_PIN = 1;
	localparam int EV_START = 2;
	// ramp slot period: one slot every RAMP_SLOT_US microseconds
	localparam int CLK_MHZ = 40;
	localparam int RAMP_SLOT_US = 100;
	localparam int RAMP_SLOT_CYC = RAMP_SLOT_US * CLK_MHZ;
endpackage : fcl_pkg

// [rtl/fcl_bank.sv]
// fan control limit register bank with apb slave and critical-temperature logic
// Notes on behaviour
// - each floor duty register resets to 0x80, half duty.
// - the floor duty code maps linearly to duty, 0x00 off, 0x40 quarter, 0xff full.
// - floor duty registers ignore writes while the automatic fan loop is on.
// - above its start temperature a channel asks for at least floor duty; start resets to 0x5a.
// - with the lock bit set, ramp, start, critical, hysteresis and test registers ignore writes.
// - any channel above its critical limit forces every pwm duty to full.
// - a critical limit of 0x80 disables forcing for that channel.
// - forced full duty holds until temperature falls below limit minus hysteresis.
// - with the pin set as output, a quarter degree above a critical limit drives it low.
// - the three critical limits reset to 0x64.
// - hysteresis is a 4-bit field, local [3:0] and remote 1 [7:4] of one register, remote 2 [7:4] of the next.
// - below start the fan stays at floor duty until start minus hysteresis is reached.
// - bit 0 of the test register enters test-tree mode, clearing it leaves; resets to zero.
// - remote 2 ramp enable bit 7 and step field [6:4] ramp duty by 1 to 48 per slot.
`timescale 1ns/1ps
module fcl_bank
	import fcl_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// temperatures: [1:0] quarter degree, [9:2] whole degrees; order remote1, local, remote2
	input wire logic [9:0] TEMP_R1,
	input wire logic [9:0] TEMP_LO,
	input wire logic [9:0] TEMP_R2,
	input wire logic [2:0] TEMP_DONE,
	input wire logic [7:0] DUTY_REQ_R2,
	input wire logic OVERTEMP_PIN_IN,
	output logic OVERTEMP_PIN_OUT,
	output logic OVERTEMP_PIN_OE_N,
	output logic [7:0] PWM1_DUTY,
	output logic [7:0] PWM2_DUTY,
	output logic [7:0] PWM3_DUTY,
	output logic [7:0] REMOTE2_RAMP_DUTY,
	output logic [2:0] CHANNEL_ACTIVE,
	output logic TEST_TREE_ON,
	output logic IRQ
);
	typedef enum logic [1:0] {
		FCL_IDLE = 2'b01,
		FCL_ACCESS = 2'b10
	} fcl_state_e;

	function automatic logic [7:0] hyst_sub(input logic [7:0] lim, input logic [3:0] h);
		hyst_sub = lim - {4'h0, h};
	endfunction : hyst_sub

	function automatic logic [7:0] ramp_step(input logic [2:0] code);
		case (code)
			3'd0: ramp_step = 8'd1;
			3'd1: ramp_step = 8'd2;
			3'd2: ramp_step = 8'd3;
			3'd3: ramp_step = 8'd4;
			3'd4: ramp_step = 8'd8;
			3'd5: ramp_step = 8'd12;
			3'd6: ramp_step = 8'd24;
			default: ramp_step = 8'd48;
		endcase
	endfunction : ramp_step

	// register state
	logic [7:0] ramp_b_r, ramp_b_nxt;
	logic [7:0] floor_r [3], floor_nxt [3];
	logic [7:0] start_r [3], start_nxt [3];
	logic [7:0] crit_r [3], crit_nxt [3];
	logic [7:0] hyst_a_r, hyst_a_nxt, hyst_b_r, hyst_b_nxt, test_r, test_nxt;
	logic [2:0] ctrl_r, ctrl_nxt, irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
	fcl_state_e state_r, state_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	// thermal state
	logic [2:0] crit_hold_r, crit_hold_nxt, act_r, act_nxt;
	logic pin_low_r, pin_low_nxt;
	logic pin_s1_r, pin_s2_r, pin_prev_r;
	logic [7:0] ramp_duty_r, ramp_duty_nxt;
	logic [12:0] slot_cnt_r, slot_cnt_nxt;
	logic [7:0] pwm_r [3], pwm_nxt [3];

	logic [9:0] temp [3];
	logic [3:0] hyst [3];
	logic wr_fire, rd_fire, locked, auto_on, hit, forced;
	logic [7:0] widx;
	logic [2:0] ev;

	assign temp[0] = TEMP_R1;
	assign temp[1] = TEMP_LO;
	assign temp[2] = TEMP_R2;
	assign hyst[0] = hyst_a_r[HYST_HI_LSB +: 4];
	assign hyst[1] = hyst_a_r[HYST_LO_LSB +: 4];
	assign hyst[2] = hyst_b_r[HYST_HI_LSB +: 4];
	assign locked = ctrl_r[CTRL_LOCK_BIT];
	assign auto_on = ctrl_r[CTRL_AUTO_BIT];
	assign widx = PADDR[9:2];
	assign wr_fire = (state_r == FCL_ACCESS) && PSEL && PENABLE && PWRITE;
	assign rd_fire = (state_r == FCL_ACCESS) && PSEL && PENABLE && !PWRITE;

	// apb slave: two wait states; pready rises on the second access edge, so every transfer ends on the third
	always_comb begin
		hit = (PADDR[1:0] == 2'b00) && (PADDR[31:10] == 22'h0) &&
			(((widx >= IDX_RAMP_B) && (widx <= IDX_TEST)) ||
			((widx >= IDX_CTRL) && (widx <= IDX_STATE)));
		state_nxt = state_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		case (state_r)
			FCL_IDLE: begin
				if (PSEL && PENABLE && !pready_r) begin
					state_nxt = FCL_ACCESS;
				end
			end
			FCL_ACCESS: begin
				state_nxt = FCL_IDLE;
				pready_nxt = 1'b1;
				pslverr_nxt = !hit;
				prdata_nxt = 32'h0000_0000;
				if (rd_fire && hit) begin
					case (widx)
						IDX_RAMP_B: prdata_nxt[7:0] = ramp_b_r;
						IDX_FLOOR1: prdata_nxt[7:0] = floor_r[0];
						IDX_FLOOR2: prdata_nxt[7:0] = floor_r[1];
						IDX_FLOOR3: prdata_nxt[7:0] = floor_r[2];
						IDX_START_R1: prdata_nxt[7:0] = start_r[0];
						IDX_START_LO: prdata_nxt[7:0] = start_r[1];
						IDX_START_R2: prdata_nxt[7:0] = start_r[2];
						IDX_CRIT_R1: prdata_nxt[7:0] = crit_r[0];
						IDX_CRIT_LO: prdata_nxt[7:0] = crit_r[1];
						IDX_CRIT_R2: prdata_nxt[7:0] = crit_r[2];
						IDX_HYST_A: prdata_nxt[7:0] = hyst_a_r;
						IDX_HYST_B: prdata_nxt[7:0] = hyst_b_r;
						IDX_TEST: prdata_nxt[7:0] = test_r;
						IDX_CTRL: prdata_nxt[2:0] = ctrl_r;
						IDX_IRQ_STAT: prdata_nxt[2:0] = irq_stat_r;
						IDX_IRQ_MASK: prdata_nxt[2:0] = irq_mask_r;
						IDX_STATE: prdata_nxt[7:0] = {pin_low_r, act_r, pin_s2_r, crit_hold_r};
						default: prdata_nxt = 32'h0000_0000;
					endcase
				end
			end
			default: state_nxt = FCL_IDLE;
		endcase
	end

	// register writes; the data is taken on the edge that also raises pready
	always_comb begin
		ramp_b_nxt = ramp_b_r;
		floor_nxt = floor_r;
		start_nxt = start_r;
		crit_nxt = crit_r;
		hyst_a_nxt = hyst_a_r;
		hyst_b_nxt = hyst_b_r;
		test_nxt = test_r;
		ctrl_nxt = ctrl_r;
		irq_mask_nxt = irq_mask_r;
		if (wr_fire && hit) begin
			case (widx)
				IDX_RAMP_B: if (!locked) ramp_b_nxt = PWDATA[7:0];
				IDX_FLOOR1: if (!auto_on) floor_nxt[0] = PWDATA[7:0];
				IDX_FLOOR2: if (!auto_on) floor_nxt[1] = PWDATA[7:0];
				IDX_FLOOR3: if (!auto_on) floor_nxt[2] = PWDATA[7:0];
				IDX_START_R1: if (!locked) start_nxt[0] = PWDATA[7:0];
				IDX_START_LO: if (!locked) start_nxt[1] = PWDATA[7:0];
				IDX_START_R2: if (!locked) start_nxt[2] = PWDATA[7:0];
				IDX_CRIT_R1: if (!locked) crit_nxt[0] = PWDATA[7:0];
				IDX_CRIT_LO: if (!locked) crit_nxt[1] = PWDATA[7:0];
				IDX_CRIT_R2: if (!locked) crit_nxt[2] = PWDATA[7:0];
				IDX_HYST_A: if (!locked) hyst_a_nxt = PWDATA[7:0];
				IDX_HYST_B: if (!locked) hyst_b_nxt = PWDATA[7:0];
				IDX_TEST: if (!locked) test_nxt = PWDATA[7:0];
				// lock is sticky until reset so a runaway driver cannot undo it
				IDX_CTRL: ctrl_nxt = PWDATA[2:0] | {2'b00, locked};
				IDX_IRQ_MASK: irq_mask_nxt = PWDATA[2:0];
				default: ctrl_nxt = ctrl_r;
			endcase
		end
	end

	// thermal comparisons; hold and active flags refresh only when a channel's measurement completes, the pin check every cycle
	always_comb begin
		crit_hold_nxt = crit_hold_r;
		act_nxt = act_r;
		pin_low_nxt = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (TEMP_DONE[i]) begin
				if (crit_r[i] == CRIT_OFF_CODE) begin
					crit_hold_nxt[i] = 1'b0;
				end else if (temp[i][9:2] > crit_r[i]) begin
					crit_hold_nxt[i] = 1'b1;
				end else if (temp[i][9:2] < hyst_sub(crit_r[i], hyst[i])) begin
					crit_hold_nxt[i] = 1'b0;
				end
				if (temp[i][9:2] > start_r[i]) begin
					act_nxt[i] = 1'b1;
				end else if (temp[i][9:2] <= hyst_sub(start_r[i], hyst[i])) begin
					act_nxt[i] = 1'b0;
				end
			end
			// pin check is on quarter degrees: at least limit plus 0.25
			if (ctrl_r[CTRL_PIN_OUT_BIT] && (crit_r[i] != CRIT_OFF_CODE) &&
				(temp[i] >= {crit_r[i], 2'b01})) begin
				pin_low_nxt = 1'b1;
			end
		end
	end

	// pwm duty: forcing overrides everything else
	always_comb begin
		forced = |crit_hold_r;
		ramp_duty_nxt = ramp_duty_r;
		slot_cnt_nxt = slot_cnt_r + 13'd1;
		if (slot_cnt_r == 13'(RAMP_SLOT_CYC - 1)) begin
			slot_cnt_nxt = 13'd0;
		end
		if (!ramp_b_r[RAMP_ON_BIT]) begin
			ramp_duty_nxt = DUTY_REQ_R2;
		end else if (slot_cnt_r == 13'd0) begin
			if (DUTY_REQ_R2 > ramp_duty_r) begin
				ramp_duty_nxt = (DUTY_REQ_R2 - ramp_duty_r > ramp_step(ramp_b_r[6:4])) ?
					ramp_duty_r + ramp_step(ramp_b_r[6:4]) : DUTY_REQ_R2;
			end else if (DUTY_REQ_R2 < ramp_duty_r) begin
				ramp_duty_nxt = (ramp_duty_r - DUTY_REQ_R2 > ramp_step(ramp_b_r[6:4])) ?
					ramp_duty_r - ramp_step(ramp_b_r[6:4]) : DUTY_REQ_R2;
			end
		end
		for (int i = 0; i < 3; i++) begin
			pwm_nxt[i] = forced ? DUTY_FULL : floor_r[i];
		end
	end

	// interrupt events: set wins over a write-one clear in the same cycle
	always_comb begin
		ev[EV_CRIT] = |(crit_hold_nxt & ~crit_hold_r);
		ev[EV_PIN] = pin_s2_r && !pin_prev_r;
		ev[EV_START] = |(act_nxt & ~act_r);
		irq_stat_nxt = irq_stat_r;
		if (wr_fire && hit && (widx == IDX_IRQ_STAT)) begin
			irq_stat_nxt = irq_stat_r & ~PWDATA[2:0];
		end
		irq_stat_nxt = irq_stat_nxt | ev;
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_r <= FCL_IDLE;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			ramp_b_r <= RST_RAMP_B;
			floor_r <= '{RST_FLOOR, RST_FLOOR, RST_FLOOR};
			start_r <= '{RST_START, RST_START, RST_START};
			crit_r <= '{RST_CRIT, RST_CRIT, RST_CRIT};
			hyst_a_r <= RST_HYST_A;
			hyst_b_r <= RST_HYST_B;
			test_r <= RST_TEST;
			ctrl_r <= 3'b000;
			irq_stat_r <= 3'b000;
			irq_mask_r <= 3'b000;
			crit_hold_r <= 3'b000;
			act_r <= 3'b000;
			pin_low_r <= 1'b0;
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			pin_prev_r <= 1'b1;
			ramp_duty_r <= 8'h00;
			slot_cnt_r <= 13'd0;
			pwm_r <= '{RST_FLOOR, RST_FLOOR, RST_FLOOR};
			IRQ <= 1'b0;
		end else begin
			state_r <= state_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			ramp_b_r <= ramp_b_nxt;
			floor_r <= floor_nxt;
			start_r <= start_nxt;
			crit_r <= crit_nxt;
			hyst_a_r <= hyst_a_nxt;
			hyst_b_r <= hyst_b_nxt;
			test_r <= test_nxt;
			ctrl_r <= ctrl_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			crit_hold_r <= crit_hold_nxt;
			act_r <= act_nxt;
			pin_low_r <= pin_low_nxt;
			// pin is active low open drain, sampled through two flops
			pin_s1_r <= OVERTEMP_PIN_IN;
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
			ramp_duty_r <= ramp_duty_nxt;
			slot_cnt_r <= slot_cnt_nxt;
			pwm_r <= pwm_nxt;
			IRQ <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign PWM1_DUTY = pwm_r[0];
	assign PWM2_DUTY = pwm_r[1];
	assign PWM3_DUTY = pwm_r[2];
	assign REMOTE2_RAMP_DUTY = ramp_duty_r;
	assign CHANNEL_ACTIVE = act_r;
	assign TEST_TREE_ON = test_r[TEST_ON_BIT];
	assign OVERTEMP_PIN_OUT = 1'b0;
	assign OVERTEMP_PIN_OE_N = !pin_low_r;

	AST_FORCE_FULL: assert property (@(posedge CLK) disable iff (RESET)
		(|crit_hold_r) |=> (PWM1_DUTY == DUTY_FULL && PWM2_DUTY == DUTY_FULL
		&& PWM3_DUTY == DUTY_FULL))
		else $error("pwm not full while critical hold set");
	AST_FLOOR_AUTO_RO: assert property (@(posedge CLK) disable iff (RESET)
		(wr_fire && auto_on && widx == IDX_FLOOR1) |=> $stable(floor_r[0]))
		else $error("floor duty changed in automatic mode");
	AST_LOCK_RO: assert property (@(posedge CLK) disable iff (RESET)
		(wr_fire && locked && widx == IDX_CRIT_LO) |=> $stable(crit_r[1]))
		else $error("locked critical limit changed");
	AST_CRIT_OFF: assert property (@(posedge CLK) disable iff (RESET)
		(TEMP_DONE[2] && crit_r[2] == CRIT_OFF_CODE) |=> !crit_hold_r[2])
		else $error("disabled critical limit still forcing");
	// hold is taken one edge after the measurement, full duty one edge later
	sequence crit_local_full;
		crit_hold_r[1] ##1 PWM2_DUTY == DUTY_FULL;
	endsequence
	AST_CRIT_SET: assert property (@(posedge CLK) disable iff (RESET)
		(TEMP_DONE[1] && crit_r[1] != CRIT_OFF_CODE && TEMP_LO[9:2] > crit_r[1])
		|=> crit_local_full)
		else $error("critical hold not taken");
	AST_CRIT_HYST: assert property (@(posedge CLK) disable iff (RESET)
		(TEMP_DONE[0] && crit_hold_r[0] && crit_r[0] != CRIT_OFF_CODE &&
		TEMP_R1[9:2] >= hyst_sub(crit_r[0], hyst[0])) |=> crit_hold_r[0])
		else $error("critical hold released inside hysteresis band");
	AST_START_HOLD: assert property (@(posedge CLK) disable iff (RESET)
		(TEMP_DONE[0] && act_r[0] && TEMP_R1[9:2] > hyst_sub(start_r[0], hyst[0]))
		|=> act_r[0])
		else $error("fan stopped inside start hysteresis band");
	AST_PIN_LOW: assert property (@(posedge CLK) disable iff (RESET)
		(!ctrl_r[CTRL_PIN_OUT_BIT]) |=> OVERTEMP_PIN_OE_N)
		else $error("pin driven while not an output");
	AST_APB_WAIT: assert property (@(posedge CLK) disable iff (RESET)
		(PSEL && PENABLE && !pready_r && state_r == FCL_IDLE) |=> ##1 PREADY)
		else $error("apb answer late");
endmodule : fcl_bank

// [verification/fcl_fan_model.sv]
// fan and overtemperature pin model standing on the pwm side of the bank
`timescale 1ns/1ps
module fcl_fan_model (
	input wire logic [7:0] pwm1_duty,
	input wire logic [7:0] pwm2_duty,
	input wire logic [7:0] pwm3_duty,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic ext_low,
	output logic pin_level,
	output int speed1_pct,
	output int speed2_pct,
	output int speed3_pct
);
	// pin has a pull-up, so a released pin reads high
	assign pin_level = ((!pin_oe_n && !pin_out) || ext_low) ? 1'b0 : 1'b1;
	// fan speed in whole percent, truncated as a tach would report it
	always_comb begin
		speed1_pct = int'(pwm1_duty) * 100 / 255;
		speed2_pct = int'(pwm2_duty) * 100 / 255;
		speed3_pct = int'(pwm3_duty) * 100 / 255;
	end
endmodule : fcl_fan_model

// [verification/fcl_bank_tb.sv]
// self-checking bench for the fan control limit bank
`timescale 1ns/1ps
module fcl_bank_tb;
	import fcl_pkg::*;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, ext_low = 0, err;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic [9:0] t_r1 = 0, t_lo = 0, t_r2 = 0;
	logic [2:0] t_done = 0, act;
	logic [7:0] duty_req = 0, pwm1, pwm2, pwm3, ramp_duty;
	logic pready, pslverr, pin_out, pin_oe_n, pin_level, test_on, irq;
	int sp1, sp2, sp3, i, mismatches = 0, checks = 0, seed = 32'hbc47;
	int tdeg[3];
	bit hold[3], actm[3], lock_m, auto_m;
	logic [7:0] model[logic [7:0]];
	logic [7:0] rstv[13] = '{RST_RAMP_B, RST_FLOOR, RST_FLOOR, RST_FLOOR, RST_START, RST_START,
		RST_START, RST_CRIT, RST_CRIT, RST_CRIT, RST_HYST_A, RST_HYST_B, RST_TEST};
	logic [7:0] codes[4] = '{8'h00, 8'h40, 8'h80, 8'hff};
	int pct[4] = '{0, 25, 50, 100};
	fcl_bank u_fcl_bank (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TEMP_R1(t_r1), .TEMP_LO(t_lo), .TEMP_R2(t_r2), .TEMP_DONE(t_done),
		.DUTY_REQ_R2(duty_req), .OVERTEMP_PIN_IN(pin_level), .OVERTEMP_PIN_OUT(pin_out),
		.OVERTEMP_PIN_OE_N(pin_oe_n), .PWM1_DUTY(pwm1), .PWM2_DUTY(pwm2), .PWM3_DUTY(pwm3),
		.REMOTE2_RAMP_DUTY(ramp_duty), .CHANNEL_ACTIVE(act), .TEST_TREE_ON(test_on), .IRQ(irq));
	fcl_fan_model u_fcl_fan_model (.pwm1_duty(pwm1), .pwm2_duty(pwm2), .pwm3_duty(pwm3),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_low(ext_low), .pin_level(pin_level),
		.speed1_pct(sp1), .speed2_pct(sp2), .speed3_pct(sp3));
	always #12.5 clk = ~clk;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic close_out();
		if (mismatches == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {22'd0, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 40);
		if (n >= 40) `CHK(pready, 1'b1)
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb(1'b1, idx, {24'd0, v});
		if (idx == IDX_CTRL) begin
			lock_m |= v[CTRL_LOCK_BIT];
			auto_m = v[CTRL_AUTO_BIT];
		end else if (idx >= IDX_FLOOR1 && idx <= IDX_FLOOR3) begin
			if (!auto_m) model[idx] = v;
		end else if (model.exists(idx) && !lock_m) model[idx] = v;
	endtask : wr
	task automatic chk_reg(input logic [7:0] idx);
		apb(1'b0, idx, 32'h0000_0000);
		`CHK(rd, {24'd0, model[idx]})
	endtask : chk_reg
	task automatic chk_out();
		bit any;
		any = hold[0] | hold[1] | hold[2];
		tick(3);
		`CHK(pwm1, any ? DUTY_FULL : model[IDX_FLOOR1])
		`CHK(pwm2, any ? DUTY_FULL : model[IDX_FLOOR2])
		`CHK(pwm3, any ? DUTY_FULL : model[IDX_FLOOR3])
		`CHK(act, {actm[2], actm[1], actm[0]})
	endtask : chk_out
	task automatic temp(input int ch, input int d, input int q);
		int lim, hy, st;
		@(posedge clk);
		if (ch == 0) t_r1 <= {d[7:0], q[1:0]};
		else if (ch == 1) t_lo <= {d[7:0], q[1:0]};
		else t_r2 <= {d[7:0], q[1:0]};
		t_done <= 3'b001 << ch;
		@(posedge clk);
		t_done <= 3'b000;
		tdeg[ch] = d;
		lim = model[IDX_CRIT_R1 + ch];
		st = model[IDX_START_R1 + ch];
		hy = ch == 0 ? model[IDX_HYST_A][7:4] : ch == 1 ? model[IDX_HYST_A][3:0] : model[IDX_HYST_B][7:4];
		if (lim == CRIT_OFF_CODE) hold[ch] = 0;
		else if (d > lim) hold[ch] = 1;
		else if (d < lim - hy) hold[ch] = 0;
		if (d > st) actm[ch] = 1;
		else if (d <= st - hy) actm[ch] = 0;
		chk_out();
	endtask : temp
	initial begin
		for (i = 0; i < 13; i++) model[IDX_RAMP_B + i] = rstv[i];
		tick(16);
		reset <= 1'b0;
		for (i = 0; i < 13; i++) chk_reg(IDX_RAMP_B + i);
		apb(1'b0, 8'h90, 32'h0000_0000);
		`CHK(err, 1'b1)
		for (i = 0; i < 4; i++) begin
			wr(IDX_FLOOR1, codes[i]);
			wr(IDX_FLOOR2, codes[i]);
			wr(IDX_FLOOR3, codes[i]);
			chk_out();
			`CHK(sp1 + sp2 + sp3, 3 * pct[i])
		end
		// reserved test bits stay zero and hysteresis stays at four degrees or more
		for (i = 0; i < 13; i++) begin
			if (i == 12) wr(IDX_RAMP_B + i, $random(seed) & 1);
			else if (i >= 10) wr(IDX_RAMP_B + i, $random(seed) | 8'h44);
			else wr(IDX_RAMP_B + i, $random(seed));
		end
		for (i = 0; i < 13; i++) chk_reg(IDX_RAMP_B + i);
		for (i = 0; i < 13; i++) wr(IDX_RAMP_B + i, rstv[i]);
		@(posedge clk);
		duty_req <= $random(seed);
		tick(4);
		`CHK(ramp_duty, duty_req)
		duty_req <= 8'h00;
		tick(3);
		// step code 100 moves the duty by 8 once per slot
		wr(IDX_RAMP_B, 8'hc0);
		duty_req <= 8'hff;
		i = 0;
		while (ramp_duty == 8'h00 && i < RAMP_SLOT_CYC + 8) begin
			tick(1);
			i++;
		end
		`CHK(ramp_duty, 8'h08)
		tick(RAMP_SLOT_CYC);
		`CHK(ramp_duty, 8'h10)
		wr(IDX_TEST, 8'h01);
		tick(3);
		`CHK(test_on, 1'b1)
		wr(IDX_TEST, 8'h00);
		tick(3);
		`CHK(test_on, 1'b0)
		wr(IDX_CTRL, 8'h02);
		wr(IDX_FLOOR1, 8'h12);
		chk_reg(IDX_FLOOR1);
		wr(IDX_CTRL, 8'h00);
		temp(1, 91, 0);
		temp(1, 87, 0);
		temp(1, 86, 0);
		wr(IDX_IRQ_STAT, 8'h07);
		wr(IDX_IRQ_MASK, 8'h00);
		temp(0, 101, 0);
		`CHK(irq, 1'b0)
		apb(1'b0, IDX_IRQ_STAT, 32'h0000_0000);
		`CHK(rd[EV_CRIT], 1'b1)
		wr(IDX_IRQ_MASK, 8'h01);
		tick(3);
		`CHK(irq, 1'b1)
		temp(0, 96, 0);
		temp(0, 95, 0);
		wr(IDX_IRQ_STAT, 8'h01);
		tick(3);
		`CHK(irq, 1'b0)
		wr(IDX_CRIT_R2, CRIT_OFF_CODE);
		temp(2, 200, 0);
		temp(2, 30, 0);
		temp(1, 105, 0);
		temp(1, 50, 0);
		wr(IDX_CTRL, 8'h04);
		temp(0, 100, 0);
		`CHK(pin_oe_n, 1'b1)
		temp(0, 100, 1);
		`CHK(pin_oe_n, 1'b0)
		`CHK(pin_level, 1'b0)
		temp(0, 50, 0);
		wr(IDX_CTRL, 8'h00);
		wr(IDX_IRQ_STAT, 8'h07);
		@(posedge clk);
		ext_low <= 1'b1;
		tick(4);
		ext_low <= 1'b0;
		apb(1'b0, IDX_IRQ_STAT, 32'h0000_0000);
		`CHK(rd[EV_PIN], 1'b1)
		wr(IDX_CTRL, 8'h01);
		for (i = 0; i < 13; i++) wr(IDX_RAMP_B + i, i == 12 ? 8'h01 : $random(seed));
		for (i = 0; i < 13; i++) chk_reg(IDX_RAMP_B + i);
		wr(IDX_CTRL, 8'h00);
		apb(1'b0, IDX_CTRL, 32'h0000_0000);
		`CHK(rd[CTRL_LOCK_BIT], 1'b1)
		close_out();
	end
	initial begin
		tick(20000);
		mismatches++;
		close_out();
	end
endmodule : fcl_bank_tb
